// ### logic/mlc_lock_msg.v
// Hardware lock and message channels with event interrupt structures.
// Assumes a single AHB-Lite master (or arbiter) on hclk; hmaster and
// hctx identify the requesting processor and its protection context.
//
// Operation
// - Up to sixteen lock and message channels
// - Up to sixteen interrupt structures from channel events
// - Five registers per channel, open to all
// - Take read claims atomically, returns won flag
// - Take read on held channel fails, returns holder identity with won flag clear
// - Successful claim records and returns holder identity
// - Any write to free register unholds channel
// - Free write ones raise release events; zero none
// - Signal write ones raise notify per structure
// - Each channel has shared 32-bit message word
// - View shows held state and holder identity now
// - Flags hold 16 notify, 16 release bits
// - Writing one clears flag, zero leaves it
// - Enable register gates flags onto interrupt
// - Writing one to force sets the flag
// - Enabled flags read as flags AND enable
// - Each structure drives one interrupt line
// - No owner check on claim or free
// - Holding never blocks message word access
`timescale 1ns/1ps
`include "mlc_defs.vh"

module mlc_lock_msg #(
    parameter NCH  = 16,
    parameter NIRQ = 16
) (
    // Clock and reset
    input  wire             hclk,
    input  wire             hresetn,
    // AHB-Lite slave
    input  wire             hsel,
    input  wire [11:0]      haddr,
    input  wire [1:0]       htrans,
    input  wire             hwrite,
    input  wire [2:0]       hsize,
    input  wire [31:0]      hwdata,
    input  wire             hready,
    input  wire [3:0]       hmaster,
    input  wire [3:0]       hctx,
    output reg  [31:0]      hrdata,
    output reg              hreadyout,
    output reg              hresp,
    // Interrupt lines, one per structure
    output reg  [NIRQ-1:0]  irq
);

    // ---------------------------------------------------------------
    // Address map
    // ---------------------------------------------------------------
    // haddr[11] set is unmapped; haddr[10] picks channels or structures,
    // haddr[8:5] the index and haddr[4:2] the register within it.
    // An index at or above NCH or NIRQ reads as zero and ignores writes.
    // Channel n at 12'h000 + n*12'h020:
    //   lock take 12'h00, event signal 12'h04, lock free 12'h08,
    //   message word 12'h0c, lock view 12'h10.
    // Structure n at 12'h400 + n*12'h020:
    //   event flags 12'h00, event force 12'h04, event enable 12'h08,
    //   enabled flags 12'h0c.
    // Lock words: bit 31 state, [11:8] context, [3:0] processor.
    // Channel and flag layouts assume at most sixteen channels.

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    // Bus phase
    reg  [11:0]        addr_r;
    reg  [7:0]         who_r;
    reg                wr_ph_r;
    reg                rd_ph_r;

    // Channel state
    reg  [NCH*32-1:0]  msg_r;
    reg  [NCH*8-1:0]   owner_r;
    reg  [NCH-1:0]     held_r;

    // Structure state
    reg  [NIRQ*32-1:0] flags_r;
    reg  [NIRQ*32-1:0] en_r;

    // Read path
    reg  [31:0]        rdata_nxt;
    wire [NCH*32-1:0]  take_words;
    wire [NCH*32-1:0]  view_words;
    wire [NIRQ*32-1:0] masked_words;

    // ---------------------------------------------------------------
    // Data phase decode
    // ---------------------------------------------------------------
    wire        accept;
    wire [4:0]  idx;
    wire [31:0] idx32;
    wire [2:0]  rsel;
    wire        in_map;
    wire        ch_ok;
    wire        is_ok;
    wire        wr_ch;
    wire        wr_is;
    wire        rd_go;
    wire        rd_ch;
    wire [15:0] ch_hot;

    assign accept = hsel & hready & htrans[1];
    assign idx    = {1'b0, addr_r[`MLC_IDX_MSB:`MLC_IDX_LSB]};
    assign idx32  = {27'h0, idx};
    assign rsel   = addr_r[`MLC_REG_MSB:`MLC_REG_LSB];
    assign in_map = ~addr_r[11];
    assign ch_ok  = in_map & ~addr_r[`MLC_REGION_BIT] & (idx32 < NCH);
    assign is_ok  = in_map & addr_r[`MLC_REGION_BIT] & (idx32 < NIRQ);
    assign wr_ch  = wr_ph_r & ch_ok;
    assign wr_is  = wr_ph_r & is_ok;
    assign rd_go  = rd_ph_r & ~hreadyout;
    assign rd_ch  = rd_go & ch_ok;
    assign ch_hot = 16'h0001 << idx[3:0];

    // Channel register strobes
    wire        take_rd;
    wire        sig_wr;
    wire        free_wr;
    wire        msg_wr;
    // Structure register strobes
    wire        flags_wr;
    wire        force_wr;
    wire        enable_wr;

    assign take_rd   = rd_ch & (rsel == `MLC_CH_LOCK_TAKE);
    assign sig_wr    = wr_ch & (rsel == `MLC_CH_EVENT_SIG);
    assign free_wr   = wr_ch & (rsel == `MLC_CH_LOCK_FREE);
    assign msg_wr    = wr_ch & (rsel == `MLC_CH_MSG_WORD);
    assign flags_wr  = wr_is & (rsel == `MLC_IS_FLAGS);
    assign force_wr  = wr_is & (rsel == `MLC_IS_FORCE);
    assign enable_wr = wr_is & (rsel == `MLC_IS_ENABLE);

    // ---------------------------------------------------------------
    // Bus handshake
    // ---------------------------------------------------------------
    // Writes complete with no wait state; reads take one wait state so that
    // a write still in its data phase is visible to the read that follows.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_r <= 12'h000;
            who_r  <= `MLC_RST_OWNER;
        end else if (accept && !rd_go) begin
            addr_r <= haddr;
            who_r  <= {hctx, hmaster};
        end
    end

    // The data phase of a write lasts exactly one cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph_r <= 1'b0;
        end else if (accept && !rd_go) begin
            wr_ph_r <= hwrite;
        end else if (hready) begin
            wr_ph_r <= 1'b0;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ph_r <= 1'b0;
        end else if (rd_go) begin
            rd_ph_r <= 1'b0;
        end else if (accept) begin
            rd_ph_r <= ~hwrite;
        end
    end

    // Low for exactly the one wait cycle of a read
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else if (rd_go) begin
            hreadyout <= 1'b1;
        end else if (accept) begin
            hreadyout <= hwrite;
        end
    end

    // Read data stands until the next read completes
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `MLC_RST_WORD;
        end else if (rd_go) begin
            hrdata <= rdata_nxt;
        end
    end

    // No access is ever refused, so the response stays OKAY
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Channels
    // ---------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < NCH; c = c + 1) begin : g_ch
            wire        sel;
            wire        claim;
            reg  [31:0] take_w;
            reg  [31:0] view_w;

            assign sel   = (idx32 == c);
            // Claim test and set happen in the single read cycle
            assign claim = take_rd & sel & ~held_r[c];

            // A write and a read data phase never overlap, so free and claim never meet
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    held_r[c] <= 1'b0;
                end else if (free_wr && sel) begin
                    held_r[c] <= 1'b0;
                end else if (claim) begin
                    held_r[c] <= 1'b1;
                end
            end

            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    owner_r[c*8 +: 8] <= `MLC_RST_OWNER;
                end else if (claim) begin
                    owner_r[c*8 +: 8] <= who_r;
                end
            end

            // Lock state does not gate the message word
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    msg_r[c*32 +: 32] <= `MLC_RST_WORD;
                end else if (msg_wr && sel) begin
                    msg_r[c*32 +: 32] <= hwdata;
                end
            end

            // Won flag plus the holder after this read
            always @* begin
                take_w              = `MLC_RST_WORD;
                take_w[`MLC_WON_BIT] = ~held_r[c];
                if (held_r[c]) begin
                    take_w[`MLC_MASTER_LSB +: 4] = owner_r[c*8 +: 4];
                    take_w[`MLC_CTX_LSB +: 4]    = owner_r[c*8+4 +: 4];
                end else begin
                    take_w[`MLC_MASTER_LSB +: 4] = who_r[3:0];
                    take_w[`MLC_CTX_LSB +: 4]    = who_r[7:4];
                end
            end
            assign take_words[c*32 +: 32] = take_w;

            // Holder fields only while held; a freed channel reads zero
            always @* begin
                view_w = `MLC_RST_WORD;
                if (held_r[c]) begin
                    view_w[`MLC_WON_BIT]         = 1'b1;
                    view_w[`MLC_MASTER_LSB +: 4] = owner_r[c*8 +: 4];
                    view_w[`MLC_CTX_LSB +: 4]    = owner_r[c*8+4 +: 4];
                end
            end
            assign view_words[c*32 +: 32] = view_w;
        end
    endgenerate

    // ---------------------------------------------------------------
    // Interrupt structures
    // ---------------------------------------------------------------
    // Event bit k of a signal or free write targets structure k.
    genvar i;
    generate
        for (i = 0; i < NIRQ; i = i + 1) begin : g_is
            wire        sel;
            wire [15:0] ntf;
            wire [15:0] rel;
            wire [31:0] frc;
            wire [31:0] clr;
            wire [31:0] setv;
            wire [31:0] cur;
            wire [31:0] masked;

            assign sel    = (idx32 == i);
            assign ntf    = (sig_wr & hwdata[i]) ? ch_hot : 16'h0000;
            assign rel    = (free_wr & hwdata[i]) ? ch_hot : 16'h0000;
            assign frc    = (force_wr & sel) ? hwdata : 32'h0000_0000;
            assign clr    = (flags_wr & sel) ? hwdata : 32'h0000_0000;
            assign setv   = {rel, ntf} | frc;
            assign cur    = flags_r[i*32 +: 32];
            assign masked = cur & en_r[i*32 +: 32];
            assign masked_words[i*32 +: 32] = masked;

            // A set arriving with its clear wins
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    flags_r[i*32 +: 32] <= `MLC_RST_WORD;
                end else begin
                    flags_r[i*32 +: 32] <= (cur & ~clr) | setv;
                end
            end

            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    en_r[i*32 +: 32] <= `MLC_RST_WORD;
                end else if (enable_wr && sel) begin
                    en_r[i*32 +: 32] <= hwdata;
                end
            end

            // One line per structure, one cycle after the flag
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    irq[i] <= 1'b0;
                end else begin
                    irq[i] <= |masked;
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // Read multiplexer
    // ---------------------------------------------------------------
    // Unmapped and write-only locations read as zero.
    always @* begin
        rdata_nxt = `MLC_RST_WORD;
        if (ch_ok) begin
            case (rsel)
                `MLC_CH_LOCK_TAKE: begin
                    // The claim itself lands on the same edge
                    rdata_nxt = take_words[idx[3:0]*32 +: 32];
                end
                `MLC_CH_MSG_WORD: begin
                    rdata_nxt = msg_r[idx[3:0]*32 +: 32];
                end
                `MLC_CH_LOCK_VIEW: begin
                    // Present state, no latency
                    rdata_nxt = view_words[idx[3:0]*32 +: 32];
                end
                default: begin
                    rdata_nxt = `MLC_RST_WORD;
                end
            endcase
        end else if (is_ok) begin
            case (rsel)
                `MLC_IS_FLAGS: begin
                    rdata_nxt = flags_r[idx[3:0]*32 +: 32];
                end
                `MLC_IS_ENABLE: begin
                    rdata_nxt = en_r[idx[3:0]*32 +: 32];
                end
                `MLC_IS_ENABLED: begin
                    rdata_nxt = masked_words[idx[3:0]*32 +: 32];
                end
                default: begin
                    rdata_nxt = `MLC_RST_WORD;
                end
            endcase
        end
    end

endmodule // mlc_lock_msg

// ### logic/mlc_defs.vh
// Constants for the multicore lock and message channel block.
// Assumes byte addresses on a 32-bit AHB-Lite bus, one word per register.
`ifndef MLC_DEFS_VH
`define MLC_DEFS_VH

// ---------------------------------------------------------------
// Address map
// ---------------------------------------------------------------
`define MLC_REGION_BIT     10
`define MLC_IDX_MSB        8
`define MLC_IDX_LSB        5
`define MLC_REG_MSB        4
`define MLC_REG_LSB        2
// Channel region, base 12'h000, stride 12'h020
`define MLC_CH_LOCK_TAKE   3'h0
`define MLC_CH_EVENT_SIG   3'h1
`define MLC_CH_LOCK_FREE   3'h2
`define MLC_CH_MSG_WORD    3'h3
`define MLC_CH_LOCK_VIEW   3'h4
// Interrupt structure region, base 12'h400, stride 12'h020
`define MLC_IS_FLAGS       3'h0
`define MLC_IS_FORCE       3'h1
`define MLC_IS_ENABLE      3'h2
`define MLC_IS_ENABLED     3'h3

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define MLC_WON_BIT        31
`define MLC_MASTER_LSB     0
`define MLC_CTX_LSB        8
`define MLC_NOTIFY_LSB     0
`define MLC_RELEASE_LSB    16

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define MLC_RST_WORD       32'h0000_0000
`define MLC_RST_OWNER      8'h00

`endif

// ### verification/mlc_lock_msg_assertions.sv
// Bus and interrupt timing checks for mlc_lock_msg.
// Assumes one master, with hready tied to hreadyout.
`timescale 1ns/1ps
module mlc_lock_msg_chk #(parameter NCH = 16, parameter NIRQ = 16) (
    // Watched ports
    input wire logic            hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
    input wire logic [11:0]     haddr,
    input wire logic [1:0]      htrans,
    input wire logic [3:0]      hmaster, hctx,
    input wire logic [31:0]     hrdata,
    input wire logic [NIRQ-1:0] irq
);
    logic       acc, rd;
    logic [2:0] age_r;
    assign acc = hsel & hready & htrans[1];
    assign rd  = acc & ~hwrite;
    // Saturating age of the last write: irq only moves shortly after one
    always @(posedge hclk or negedge hresetn)
        if (!hresetn) age_r <= 3'h7;
        else if (acc & hwrite) age_r <= 3'h0;
        else if (age_r != 3'h7) age_r <= age_r + 3'h1;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_read; rd; endsequence
    sequence s_rd_wait; !hreadyout ##1 hreadyout; endsequence
    property p_okay; hresp == 1'b0; endproperty
    property p_wr_nowait; acc && hwrite |=> hreadyout; endproperty
    property p_rd_wait; s_read |=> s_rd_wait; endproperty
    property p_take_id; s_read ##0 (haddr[11:10] == 2'h0 && haddr[4:2] == 3'h0) ##2 hrdata[31]
        |-> hrdata[3:0] == $past(hmaster, 2) && hrdata[11:8] == $past(hctx, 2); endproperty
    property p_wo_zero; s_read ##0 (haddr[11:10] == 2'h0 && haddr[4:2] inside {3'h1, 3'h2})
        |-> ##2 hrdata == 32'h0; endproperty
    property p_unmapped; s_read ##0 haddr[11] |-> ##2 hrdata == 32'h0; endproperty
    property p_rdata_hold; $changed(hrdata) |-> $past(rd, 2); endproperty
    property p_irq_cause; $changed(irq) |-> age_r <= 3'h3; endproperty
    property p_irq_reset; $rose(hresetn) |-> irq == '0; endproperty
    a_okay: assert property (p_okay) else $error("non-OKAY response");
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    a_take_id: assert property (p_take_id) else $error("holder id wrong");
    a_wo_zero: assert property (p_wo_zero) else $error("write-only read not zero");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_rdata_hold: assert property (p_rdata_hold) else $error("hrdata moved");
    a_irq_cause: assert property (p_irq_cause) else $error("irq moved alone");
    a_irq_reset: assert property (p_irq_reset) else $error("irq high at reset");
endmodule // mlc_lock_msg_chk
bind mlc_lock_msg mlc_lock_msg_chk #(.NCH(NCH), .NIRQ(NIRQ)) i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .haddr(haddr), .htrans(htrans),
    .hmaster(hmaster), .hctx(hctx), .hrdata(hrdata), .irq(irq));

// ### verification/mlc_ahb_master.sv
// Processors sharing the bus, as one AHB-Lite master.
// Context is derived from the id so both fields vary.
`timescale 1ns/1ps
module mlc_ahb_master (
    // Clock and answer
    input  wire logic        hclk, hready,
    input  wire logic [31:0] hrdata,
    // Request
    output logic             hsel, hwrite,
    output logic [11:0]      haddr,
    output logic [1:0]       htrans,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    output logic [3:0]       hmaster, hctx
);
    initial {hsel, hwrite, haddr, htrans, hsize, hwdata, hmaster, hctx} = '0;
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] id,
                        output logic [31:0] q);
        {hsel, htrans, haddr, hwrite, hsize, hmaster, hctx} <= {1'b1, 2'h2, a, w, 3'h2, id, ~id};
        do @(posedge hclk); while (hready !== 1'b1);
        {hsel, htrans} <= 3'h0;
        hwdata <= w ? d : ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        // Released data lines must not keep the last value
        hwdata <= ~hwdata;
    endtask
endmodule // mlc_ahb_master

// ### verification/test_mlc_lock_msg.sv
// Self-checking bench for mlc_lock_msg, 16 channels and structures.
// Assumes the master model and the bound checker.
`timescale 1ns/1ps
module test_mlc_lock_msg;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, q;
    logic [3:0]  hmaster, hctx;
    logic [15:0] irq;
    int          err_total = 0, check_count = 0, cyc = 0, c;
    mlc_lock_msg i_mlc_lock_msg (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hmaster(hmaster), .hctx(hctx),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
    mlc_ahb_master i_mlc_ahb_master (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .hwrite(hwrite), .haddr(haddr), .htrans(htrans), .hsize(hsize), .hwdata(hwdata), .hmaster(hmaster),
        .hctx(hctx));
    initial begin hclk = 1'b0; forever #5 hclk = ~hclk; end
    function automatic logic [11:0] ch(int n, int r); return 12'(n * 32 + r * 4); endfunction
    function automatic logic [11:0] ia(int n, int r); return 12'(1024 + n * 32 + r * 4); endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] id = 4'h1);
        i_mlc_ahb_master.xfer(1'b1, a, d, id, q);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] exp, input logic [3:0] id = 4'h1);
        i_mlc_ahb_master.xfer(1'b0, a, 32'h0, id, q);
        chk(q, exp);
    endtask
    task automatic irq_is(input logic [15:0] exp);
        repeat (2) @(posedge hclk);
        chk({16'h0, irq}, {16'h0, exp});
    endtask
    task final_report;
        $display("Mismatches %0d, checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin err_total++; final_report; end
    end
    initial begin
        hresetn = 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc(ch(0, 4), 0);
        rc(ia(0, 0), 0);
        // Lowest and highest channel; holder id 3 gives context c
        for (int k = 0; k < 2; k++) begin
            c = k * 15;
            rc(ch(c, 0), 32'h8000_0c03, 4'h3);
            rc(ch(c, 0), 32'h0000_0c03, 4'h5);
            rc(ch(c, 4), 32'h8000_0c03, 4'h5);
            wr(ch(c, 3), 32'hdead_beef + c, 4'h9);
            rc(ch(c, 3), 32'hdead_beef + c, 4'h5);
            wr(ch(c, 2), 32'h0, 4'h5);
            rc(ch(c, 4), 0);
            wr(ch(c, 2), 32'h2);
            rc(ch(c, 4), 0);
        end
        rc(ia(1, 0), 32'h8001_0000);
        rc(ia(0, 0), 0);
        // Sender claims, fills, notifies structures 0 and 2
        rc(ch(4, 0), 32'h8000_0c03, 4'h3);
        wr(ch(4, 3), 32'h1234_5678, 4'h3);
        wr(ch(4, 1), 32'h5, 4'h3);
        irq_is(16'h0);
        rc(ia(0, 0), 32'h10);
        rc(ia(2, 0), 32'h10);
        wr(ia(2, 2), 32'h10);
        irq_is(16'h4);
        rc(ia(2, 3), 32'h10);
        wr(ia(2, 1), 32'h0001_0000);
        rc(ia(2, 0), 32'h0001_0010);
        rc(ia(2, 3), 32'h10);
        wr(ia(2, 0), 32'h10);
        rc(ia(2, 0), 32'h0001_0000);
        irq_is(16'h0);
        // Receiver reads, then frees with a release to structure 2
        rc(ch(4, 3), 32'h1234_5678, 4'h7);
        wr(ch(4, 2), 32'h4, 4'h7);
        rc(ia(2, 0), 32'h0011_0000);
        rc(ch(4, 4), 0);
        wr(12'h800, 32'hffff_ffff);
        rc(12'h800, 0);
        rc(ch(0, 1), 0);
        final_report;
    end
endmodule // test_mlc_lock_msg
